// ---- hw/nvsc_cmd_unit.v ----
// Overview of operation
// RULE1: software store always copies the whole sram to nonvolatile cells.
// RULE2: store needs write latch set; latch clears at chip select rise.
// RULE3: recall reloads sram; needs latch; latch clears at chip select rise.
// RULE4: auto-save enable needs latch; volatile until stored; latch clears.
// RULE5: enable/disable report busy for sequence time; no effect without auto-save; code reports busy only when HAS_AUTO_SAVE is set.
// RULE6: auto-save on by default where present; disable turns it off.
// RULE7: auto-save disable needs latch; latch clears at chip select rise.
// RULE8: sleep takes sequence time, drives busy pin low, stores, then sleeps; code sets asleep in the same cycle the store starts.
// RULE9: sleep store runs only if sram written since last store or recall.
// RULE10: asleep: ignore clock and input, output floats, watch chip select.
// RULE11: chip select fall wakes; ready only after wake delay.
// RULE12: eight serial bytes default zero; no checksum computed.
// RULE13: serial write needs latch, bursts up to eight bytes, clears latch.
// RULE14: with lock bit set, serial write is ignored.
// RULE15: stored lock bit is never cleared by the device.
// RULE16: serial read shifts out eight bytes, no wrap.
// RULE17: fast serial read skips one dummy byte, then eight bytes.
// RULE18: id word: maker 31-21, product 20-7, density 6-3, revision 2-0.
// RULE19: maker code: upper three bits bank, lower eight number.
// RULE20: id read shifts out four id bytes.
// RULE21: fast id read skips one dummy byte, then four bytes.
// RULE22: opcodes 3C store, 60 recall, 59 enable, 19 disable.
// RULE23: busy shown on ready bit and busy pin during store or recall.
// RULE24: with latch clear, protected commands are ignored.
// RULE25: other opcodes are configurable constants.
// RULE26: timings are parameterised cycle counts from the device clock.
`timescale 1ns/1ns
`default_nettype none
`include "nvsc_defines.vh"

module nvsc_cmd_unit
#(
	parameter       HAS_AUTO_SAVE = 1,
	parameter [7:0] OP_SLEEP      = `NVSC_OP_SLEEP,
	parameter [7:0] OP_SN_WRITE   = `NVSC_OP_SN_WRITE,
	parameter [7:0] OP_SN_READ    = `NVSC_OP_SN_READ,
	parameter [7:0] OP_SN_FREAD   = `NVSC_OP_SN_FREAD,
	parameter [7:0] OP_ID_READ    = `NVSC_OP_ID_READ,
	parameter [7:0] OP_ID_FREAD   = `NVSC_OP_ID_FREAD
)
(
	// clock and reset
	input  wire i_clk_sys,
	input  wire i_rst,
	// spi pins
	input  wire i_cs_n,
	input  wire i_sck,
	input  wire i_si,
	output reg  o_so,
	output reg  o_so_oe,
	// device core links
	input  wire i_sram_written,
	input  wire i_lock_set,
	output reg  o_store_busy_pin_n,
	output reg  o_ready_n,
	output reg  o_write_latch,
	output reg  o_serial_lock_bit,
	output reg  o_power_loss_save,
	output reg  o_store_pulse,
	output reg  o_recall_pulse,
	output reg  o_asleep
);

	// ==========================================
	// states
	localparam [2:0] ST_OP    = 3'h0;
	localparam [2:0] ST_DUMMY = 3'h1;
	localparam [2:0] ST_SNW   = 3'h2;
	localparam [2:0] ST_OUT   = 3'h3;
	localparam [2:0] ST_DONE  = 3'h4;

	localparam [31:0] ID_WORD = {`NVSC_ID_BANK, `NVSC_ID_MAKER, `NVSC_ID_PRODUCT,
		`NVSC_ID_DENSITY, `NVSC_ID_REV}; // RULE18 RULE19

	function [15:0] cyc16;
		input integer n;
		begin
			cyc16 = (n < 1) ? 16'h0001 : n[15:0];
		end
	endfunction

	// ==========================================
	// pin synchronisers
	reg [1:0] cs_s;
	reg [1:0] sck_s;
	reg [1:0] si_s;
	reg       cs_d;
	reg       sck_d;

	always @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			cs_s  <= 2'b11;
			sck_s <= 2'b00;
			si_s  <= 2'b00;
			cs_d  <= 1'b1;
			sck_d <= 1'b0;
		end
		else
		begin
			cs_s  <= {cs_s[0], i_cs_n};
			sck_s <= {sck_s[0], i_sck};
			si_s  <= {si_s[0], i_si};
			cs_d  <= cs_s[1];
			sck_d <= sck_s[1];
		end
	end

	wire cs_low  = ~cs_s[1];
	wire cs_fall = cs_d & ~cs_s[1];
	wire cs_rise = ~cs_d & cs_s[1];
	wire sck_up  = cs_low & ~sck_d & sck_s[1];
	wire sck_dn  = cs_low & sck_d & ~sck_s[1];

	// ==========================================
	// timers and serial memory
	reg         seq_start;
	reg         nv_start;
	reg         wake_start;
	reg  [15:0] nv_len;
	wire        seq_busy;
	wire        nv_busy;
	wire        wake_busy;
	reg         sn_we;
	reg  [2:0]  sn_waddr;
	reg  [2:0]  sn_raddr;
	wire [7:0]  sn_rdata;
	reg  [7:0]  shreg;

	nvsc_timer u_seq
	(
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_start   (seq_start),
		.i_len     (cyc16(`NVSC_SEQ_CYC)),
		.o_busy    (seq_busy)
	); // RULE26

	nvsc_timer u_nv
	(
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_start   (nv_start),
		.i_len     (nv_len),
		.o_busy    (nv_busy)
	);

	nvsc_timer u_wake
	(
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_start   (wake_start),
		.i_len     (cyc16(`NVSC_WAKE_CYC)),
		.o_busy    (wake_busy)
	);

	nvsc_sn_mem u_sn
	(
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_we      (sn_we),
		.i_waddr   (sn_waddr),
		.i_wdata   (shreg),
		.i_raddr   (sn_raddr),
		.o_rdata   (sn_rdata)
	); // RULE12

	// ==========================================
	// command engine
	reg [2:0]  state;
	reg [2:0]  bitcnt;
	reg [7:0]  op;
	reg [3:0]  bytecnt;
	reg [3:0]  nbytes;
	reg [7:0]  outbyte;
	reg        load_out;
	reg        dirty;
	reg        sleep_pend;
	reg        sleep_store;
	reg        lock_saved;
	reg        clr_wel;

	wire [7:0] byte_in = {shreg[6:0], si_s[1]};
	wire       busy    = seq_busy | nv_busy | wake_busy | sleep_pend;
	wire [7:0] id_byte = ID_WORD[8'd31 - {bytecnt[1:0], 3'h0} -: 8];

	always @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			state              <= ST_OP;
			shreg              <= 8'h00;
			bitcnt             <= 3'h0;
			op                 <= 8'h00;
			bytecnt            <= 4'h0;
			nbytes             <= 4'h0;
			outbyte            <= 8'h00;
			load_out           <= 1'b0;
			dirty              <= 1'b0;
			sleep_pend         <= 1'b0;
			sleep_store        <= 1'b0;
			lock_saved         <= 1'b0;
			clr_wel            <= 1'b0;
			seq_start          <= 1'b0;
			nv_start           <= 1'b0;
			wake_start         <= 1'b0;
			nv_len             <= 16'h0001;
			sn_we              <= 1'b0;
			sn_waddr           <= 3'h0;
			sn_raddr           <= 3'h0;
			o_so               <= 1'b0;
			o_so_oe            <= 1'b0;
			o_store_busy_pin_n <= 1'b1;
			o_ready_n          <= 1'b0;
			o_write_latch      <= 1'b0;
			o_serial_lock_bit  <= 1'b0;
			o_power_loss_save  <= (HAS_AUTO_SAVE != 0); // RULE6
			o_store_pulse      <= 1'b0;
			o_recall_pulse     <= 1'b0;
			o_asleep           <= 1'b0;
		end
		else
		begin
			seq_start      <= 1'b0;
			nv_start       <= 1'b0;
			wake_start     <= 1'b0;
			sn_we          <= 1'b0;
			o_store_pulse  <= 1'b0;
			o_recall_pulse <= 1'b0;
			o_ready_n      <= busy;
			o_store_busy_pin_n <= ~(nv_busy | sleep_store); // RULE23
			if (i_lock_set)
				o_serial_lock_bit <= 1'b1;
			if (o_store_pulse)
				lock_saved <= lock_saved | o_serial_lock_bit; // RULE15
			// sleep: after sequence time, enter sleep and, if dirty, start a store in the same cycle
			if (sleep_pend & ~seq_busy & ~seq_start)
			begin
				sleep_pend <= 1'b0;
				o_asleep   <= 1'b1; // RULE8
				if (dirty) // RULE9
				begin
					nv_start      <= 1'b1;
					nv_len        <= cyc16(`NVSC_STORE_CYC);
					o_store_pulse <= 1'b1;
					sleep_store   <= 1'b1;
					dirty         <= 1'b0;
					lock_saved    <= lock_saved | o_serial_lock_bit;
				end
			end
			if (sleep_store & ~nv_busy & ~nv_start)
				sleep_store <= 1'b0;
			if (o_asleep)
			begin
				o_so_oe <= 1'b0; // RULE10
				if (cs_fall)
				begin
					o_asleep   <= 1'b0;
					wake_start <= 1'b1; // RULE11
				end
				state <= ST_DONE;
			end
			else if (cs_rise | ~cs_low)
			begin
				state   <= ST_OP;
				bitcnt  <= 3'h0;
				bytecnt <= 4'h0;
				o_so_oe <= 1'b0;
				if (cs_rise & clr_wel)
					o_write_latch <= 1'b0; // RULE2 RULE3 RULE4 RULE7 RULE13
				if (cs_rise)
					clr_wel <= 1'b0;
			end
			else
			begin
				if (sck_up)
				begin
					shreg  <= byte_in;
					bitcnt <= bitcnt + 3'h1;
				end
				if (sck_up & (bitcnt == 3'h7))
				begin
					case (state)
						ST_OP:
						begin
							op    <= byte_in;
							state <= ST_DONE;
							if (busy)
								state <= ST_DONE; // RULE11 RULE23
							else if (byte_in == `NVSC_OP_SET_WEL)
								o_write_latch <= 1'b1;
							else if ((byte_in == `NVSC_OP_STORE) & o_write_latch) // RULE22 RULE24
							begin
								clr_wel       <= 1'b1;
								nv_start      <= 1'b1;
								nv_len        <= cyc16(`NVSC_STORE_CYC);
								o_store_pulse <= 1'b1; // RULE1
								dirty         <= 1'b0;
							end
							else if ((byte_in == `NVSC_OP_RECALL) & o_write_latch)
							begin
								clr_wel        <= 1'b1;
								nv_start       <= 1'b1;
								nv_len         <= cyc16(`NVSC_STORE_CYC);
								o_recall_pulse <= 1'b1;
								dirty          <= 1'b0;
							end
							else if (((byte_in == `NVSC_OP_SAVE_EN) | (byte_in == `NVSC_OP_SAVE_DIS))
								& o_write_latch)
							begin
								clr_wel <= 1'b1;
								if (HAS_AUTO_SAVE != 0) // RULE5
								begin
									seq_start         <= 1'b1;
									o_power_loss_save <= (byte_in == `NVSC_OP_SAVE_EN); // RULE4 RULE6
								end
							end
							else if (byte_in == OP_SLEEP) // RULE25
							begin
								seq_start  <= 1'b1;
								sleep_pend <= 1'b1;
							end
							else if ((byte_in == OP_SN_WRITE) & o_write_latch)
							begin
								clr_wel <= 1'b1;
								if (~o_serial_lock_bit & ~lock_saved) // RULE14
									state <= ST_SNW;
							end
							else if ((byte_in == OP_SN_READ) | (byte_in == OP_ID_READ))
							begin
								state    <= ST_OUT;
								load_out <= 1'b1;
								nbytes   <= (byte_in == OP_SN_READ) ? 4'h8 : 4'h4; // RULE16 RULE20
							end
							else if ((byte_in == OP_SN_FREAD) | (byte_in == OP_ID_FREAD))
							begin
								state  <= ST_DUMMY; // RULE17 RULE21
								nbytes <= (byte_in == OP_SN_FREAD) ? 4'h8 : 4'h4;
							end
						end
						ST_DUMMY:
						begin
							state    <= ST_OUT;
							load_out <= 1'b1;
						end
						ST_SNW:
						begin
							sn_we    <= 1'b1; // RULE13
							sn_waddr <= bytecnt[2:0];
							bytecnt  <= bytecnt + 4'h1;
							if (bytecnt == 4'h7)
								state <= ST_DONE;
						end
						ST_OUT:
						begin
							bytecnt  <= bytecnt + 4'h1;
							load_out <= 1'b1;
							if (bytecnt + 4'h1 == nbytes)
								state <= ST_DONE; // RULE16 RULE17
						end
						default:
							state <= ST_DONE;
					endcase
				end
				// look one byte ahead so the registered read has settled when the next byte loads
				sn_raddr <= ((state == ST_OUT) & (bitcnt == 3'h7)) ? (bytecnt[2:0] + 3'h1) : bytecnt[2:0];
				if (load_out & ~sck_up)
				begin
					load_out <= 1'b0;
					outbyte  <= ((op == OP_SN_READ) | (op == OP_SN_FREAD)) ? sn_rdata : id_byte;
				end
				if (sck_dn & (state == ST_OUT))
				begin
					o_so_oe <= 1'b1;
					o_so    <= outbyte[3'h7 - bitcnt];
				end
				else if (sck_dn)
					o_so_oe <= 1'b0;
			end
			// a write landing with a store start still marks the array dirty
			if (i_sram_written)
				dirty <= 1'b1;
		end
	end

endmodule // nvsc_cmd_unit
`default_nettype wire

// ---- hw/nvsc_defines.vh ----
`ifndef NVSC_DEFINES_VH
`define NVSC_DEFINES_VH

// ==========================================
// opcodes
`define NVSC_OP_STORE        8'h3C
`define NVSC_OP_RECALL       8'h60
`define NVSC_OP_SAVE_EN      8'h59
`define NVSC_OP_SAVE_DIS     8'h19
`define NVSC_OP_SET_WEL      8'h06
`define NVSC_OP_SLEEP        8'hB9
`define NVSC_OP_SN_WRITE     8'hC2
`define NVSC_OP_SN_READ      8'hC3
`define NVSC_OP_SN_FREAD     8'hC9
`define NVSC_OP_ID_READ      8'h9F
`define NVSC_OP_ID_FREAD     8'h99

// ==========================================
// identification word fields (values arbitrary)
`define NVSC_ID_BANK         3'h1
`define NVSC_ID_MAKER        8'h5A
`define NVSC_ID_PRODUCT      14'h0123
`define NVSC_ID_DENSITY      4'h7
`define NVSC_ID_REV          3'h1
`define NVSC_ID_MAKER_MSB    31
`define NVSC_ID_MAKER_LSB    21
`define NVSC_ID_PROD_LSB     7
`define NVSC_ID_DENS_LSB     3

// ==========================================
// serial number
`define NVSC_SN_BYTES        8
`define NVSC_SN_RESET        8'h00

// ==========================================
// timing in ns and derived cycles at 50 ns
`define NVSC_CLK_NS          50
`define NVSC_T_SEQ_NS        500
`define NVSC_T_WAKE_NS       1000
`define NVSC_T_STORE_NS      2000
`define NVSC_SEQ_CYC         ((`NVSC_T_SEQ_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_WAKE_CYC        ((`NVSC_T_WAKE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_STORE_CYC       ((`NVSC_T_STORE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)

`endif

// ---- hw/nvsc_sn_mem.v ----
`timescale 1ns/1ns
`default_nettype none
`include "nvsc_defines.vh"

module nvsc_sn_mem
(
	// clock and reset
	input  wire       i_clk_sys,
	input  wire       i_rst,
	// write port
	input  wire       i_we,
	input  wire [2:0] i_waddr,
	input  wire [7:0] i_wdata,
	// read port
	input  wire [2:0] i_raddr,
	output reg  [7:0] o_rdata
);

	reg [7:0] mem [0:`NVSC_SN_BYTES-1];
	integer   k;

	always @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			for (k = 0; k < `NVSC_SN_BYTES; k = k + 1)
				mem[k] <= `NVSC_SN_RESET;
			o_rdata <= 8'h00;
		end
		else
		begin
			if (i_we)
				mem[i_waddr] <= i_wdata;
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // nvsc_sn_mem
`default_nettype wire

// ---- hw/nvsc_timer.v ----
`timescale 1ns/1ns
`default_nettype none

module nvsc_timer
(
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rst,
	// control
	input  wire        i_start,
	input  wire [15:0] i_len,
	output reg         o_busy
);

	reg [15:0] cnt;

	always @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt    <= 16'h0000;
			o_busy <= 1'b0;
		end
		else if (i_start)
		begin
			cnt    <= i_len;
			o_busy <= 1'b1;
		end
		else if (cnt > 16'h0001)
			cnt <= cnt - 16'h0001;
		else
		begin
			cnt    <= 16'h0000;
			o_busy <= 1'b0;
		end
	end

endmodule // nvsc_timer
`default_nettype wire

// ---- test/nvsc_chk_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvsc_chk
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// spi pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic o_so,
	input wire logic o_so_oe,
	// core links
	input wire logic i_sram_written,
	input wire logic i_lock_set,
	input wire logic o_store_busy_pin_n,
	input wire logic o_ready_n,
	input wire logic o_write_latch,
	input wire logic o_serial_lock_bit,
	input wire logic o_power_loss_save,
	input wire logic o_store_pulse,
	input wire logic o_recall_pulse,
	input wire logic o_asleep
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// ==========================================
	// length of each busy pin low phase
	logic [7:0] low_cnt;
	always @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst || o_store_busy_pin_n)
			low_cnt <= 8'h00;
		else
			low_cnt <= low_cnt + 8'h01;
	end
	// ==========================================
	AST_STORE_PIN: assert property (o_store_pulse |-> ##[1:2] !o_store_busy_pin_n)
		else $error("busy pin not low after store start");
	AST_STORE_LEN: assert property ($rose(o_store_busy_pin_n) |-> low_cnt >= 8'd39 && low_cnt <= 8'd51)
		else $error("busy pin low phase of wrong length");
	AST_LATCH_CLR: assert property ($fell(o_write_latch) |-> $past(i_cs_n, 2))
		else $error("write latch cleared with chip select low");
	AST_RECALL_GUARD: assert property (o_recall_pulse |-> o_write_latch)
		else $error("recall started without write latch");
	AST_PULSE_ONE: assert property (o_store_pulse |=> !o_store_pulse)
		else $error("store pulse longer than one cycle");
	AST_SLEEP_FLOAT: assert property (o_asleep |-> !o_so_oe)
		else $error("serial out driven while asleep");
	AST_WAKE_DELAY: assert property (o_asleep && $fell(i_cs_n) |-> ##5 o_ready_n [*8])
		else $error("ready before wake delay");
	AST_SEQ_BUSY: assert property ($changed(o_power_loss_save) |-> ##[0:2] o_ready_n [*5])
		else $error("no busy after auto save change");
	AST_LOCK_KEEP: assert property (!$fell(o_serial_lock_bit))
		else $error("serial lock bit cleared");
endmodule // nvsc_chk
bind nvsc_cmd_unit nvsc_chk nvsc_chk_inst (.*);
`default_nettype wire

// ---- test/nvsc_spi_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvsc_spi_host
(
	// clock
	input  wire logic i_clk_sys,
	// spi pins
	input  wire logic i_so,
	input  wire logic i_so_oe,
	output var  logic o_cs_n,
	output var  logic o_sck,
	output var  logic o_si
);
	logic so_seen;
	initial
	begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_si   = 1'b0;
	end
	// a floating output reads back inverted so it never passes as data
	assign so_seen = i_so_oe ? i_so : ~i_so;
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	// mode 0, msb first, 400 ns link period, clock idles low
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--)
		begin
			o_si = tx[b];
			tick(4);
			o_sck = 1'b1;
			rx[b] = so_seen;
			tick(4);
			o_sck = 1'b0;
		end
	endtask
	task automatic open_frame();
		tick(1);
		o_cs_n = 1'b0;
		tick(4);
	endtask
	task automatic close_frame();
		tick(4);
		o_cs_n = 1'b1;
		o_si = ~o_si;
		tick(8);
	endtask
endmodule // nvsc_spi_host
`default_nettype wire

// ---- test/nvsc_cmd_unit_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "nvsc_defines.vh"
module nvsc_cmd_unit_tb;
	logic i_clk_sys, i_rst, i_cs_n, i_sck, i_si, o_so, o_so_oe, i_sram_written, i_lock_set;
	logic o_store_busy_pin_n, o_ready_n, o_write_latch, o_serial_lock_bit;
	logic o_power_loss_save, o_store_pulse, o_recall_pulse, o_asleep;
	int mismatches, n_compared, n_store, n_recall, cyc;
	logic [7:0]  rx;
	logic [63:0] d, sn_exp, id_exp;
	nvsc_cmd_unit nvsc_cmd_unit_inst (.*);
	nvsc_spi_host nvsc_spi_host_inst (.i_clk_sys(i_clk_sys), .i_so(o_so), .i_so_oe(o_so_oe),
		.o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si));
	initial
	begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys)
	begin
		n_store += (o_store_pulse === 1'b1);
		n_recall += (o_recall_pulse === 1'b1);
		cyc++;
		if (cyc > 30000)
		begin
			mismatches++;
			close_out();
		end
	end
	// ==========================================
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		nvsc_spi_host_inst.open_frame();
		nvsc_spi_host_inst.xbyte(op, rx);
		nvsc_spi_host_inst.close_frame();
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while ((o_ready_n !== 1'b0 || o_store_busy_pin_n !== 1'b1) && k < 400)
		begin
			@(posedge i_clk_sys);
			k++;
		end
		check("idle", k < 400, 1'b1);
		#1;
	endtask
	task automatic guarded(input logic [7:0] op);
		cmd(`NVSC_OP_SET_WEL);
		cmd(op);
		wait_idle();
		check("latch", o_write_latch, 1'b0);
	endtask
	task automatic rd(input logic [7:0] op, input bit dummy, input int n);
		nvsc_spi_host_inst.open_frame();
		nvsc_spi_host_inst.xbyte(op, rx);
		if (dummy)
			nvsc_spi_host_inst.xbyte(8'hA5, rx);
		d = '0;
		for (int i = 0; i < n; i++)
		begin
			nvsc_spi_host_inst.xbyte(8'h00, rx);
			d = {d[55:0], rx};
		end
		nvsc_spi_host_inst.xbyte(8'h00, rx);
		check("no wrap", o_so_oe, 1'b0);
		nvsc_spi_host_inst.close_frame();
	endtask
	task automatic sn_write(input logic [7:0] base);
		cmd(`NVSC_OP_SET_WEL);
		nvsc_spi_host_inst.open_frame();
		nvsc_spi_host_inst.xbyte(`NVSC_OP_SN_WRITE, rx);
		for (int i = 0; i < 9; i++)
			nvsc_spi_host_inst.xbyte(base + 8'(i), rx);
		nvsc_spi_host_inst.close_frame();
	endtask
	task automatic pulse_in(input bit lock);
		nvsc_spi_host_inst.tick(1);
		{i_lock_set, i_sram_written} = {lock, !lock};
		nvsc_spi_host_inst.tick(1);
		{i_lock_set, i_sram_written} = 2'b00;
	endtask
	// ==========================================
	initial
	begin
		{mismatches, n_compared, n_store, n_recall, cyc} = '0;
		{i_rst, i_sram_written, i_lock_set} = 3'b100;
		repeat (5) @(posedge i_clk_sys);
		#1 i_rst = 1'b0;
		nvsc_spi_host_inst.tick(3);
		check("save default", o_power_loss_save, 1'b1);
		check("lock reset", o_serial_lock_bit, 1'b0);
		id_exp = {`NVSC_ID_BANK, `NVSC_ID_MAKER, `NVSC_ID_PRODUCT, `NVSC_ID_DENSITY, `NVSC_ID_REV};
		rd(`NVSC_OP_ID_READ, 0, 4);
		check("id", d, id_exp);
		rd(`NVSC_OP_SN_READ, 0, 8);
		check("sn default", d, 64'h0);
		cmd(`NVSC_OP_STORE);
		wait_idle();
		check("unlatched store", n_store, 0);
		guarded(`NVSC_OP_STORE);
		check("store", n_store, 1);
		guarded(`NVSC_OP_RECALL);
		check("recall", n_recall, 1);
		guarded(`NVSC_OP_SAVE_DIS);
		check("save off", o_power_loss_save, 1'b0);
		cmd(`NVSC_OP_SAVE_EN);
		wait_idle();
		check("unlatched enable", o_power_loss_save, 1'b0);
		guarded(`NVSC_OP_SAVE_EN);
		check("save on", o_power_loss_save, 1'b1);
		sn_write(8'h11);
		sn_exp = 64'h1112131415161718;
		rd(`NVSC_OP_SN_FREAD, 1, 8);
		check("sn written", d, sn_exp);
		pulse_in(1'b1);
		check("lock", o_serial_lock_bit, 1'b1);
		sn_write(8'h40);
		rd(`NVSC_OP_SN_READ, 0, 8);
		check("sn locked", d, sn_exp);
		guarded(`NVSC_OP_STORE);
		rd(`NVSC_OP_ID_FREAD, 1, 4);
		check("fast id", d, id_exp);
		for (int s = 0; s < 2; s++)
		begin
			if (s == 0)
				pulse_in(1'b0);
			cmd(`NVSC_OP_SLEEP);
			for (int k = 0; k < 200 && o_asleep !== 1'b1; k++)
				nvsc_spi_host_inst.tick(1);
			check("asleep", o_asleep, 1'b1);
			check("sleep store", n_store, 3);
			nvsc_spi_host_inst.open_frame();
			nvsc_spi_host_inst.tick(25);
			nvsc_spi_host_inst.close_frame();
			wait_idle();
			check("awake", o_asleep, 1'b0);
		end
		close_out();
	end
endmodule // nvsc_cmd_unit_tb
`default_nettype wire
